// >>> pcb_params.svh
// Constants for the power command bank: codes, fields, resets, host port map, op codes
`ifndef PCB_PARAMS_SVH
`define PCB_PARAMS_SVH
// Command codes
`define PCB_CMD_TURN_ON        8'h01
`define PCB_CMD_ON_OFF_CFG     8'h02
`define PCB_CMD_CLEAR_FAULTS   8'h03
`define PCB_CMD_WRITE_LOCK     8'h10
`define PCB_CMD_RESTORE_DEF    8'h12
`define PCB_CMD_STORE_USER     8'h15
`define PCB_CMD_RESTORE_USER   8'h16
`define PCB_CMD_BUS_FEATURE    8'h19
`define PCB_CMD_VOUT_FORMAT    8'h20
`define PCB_CMD_VOUT_SETPOINT  8'h21
`define PCB_CMD_LOOP_SCALE     8'h29
`define PCB_CMD_MON_SCALE      8'h2A
`define PCB_CMD_VIN_START      8'h35
// Field positions
`define PCB_TURN_ON_ENABLE_BIT 7
`define PCB_CFG_POWERUP_BIT    4
`define PCB_CFG_CMD_EN_BIT     3
`define PCB_CFG_PIN_EN_BIT     2
`define PCB_CFG_POLARITY_BIT   1
`define PCB_LOCK_ALL_BIT       7
`define PCB_LOCK_MOST_BIT      6
`define PCB_LOCK_SOME_BIT      5
// Writable masks and fixed read values
`define PCB_TURN_ON_WMASK      16'h0080
`define PCB_TURN_ON_FIXED      16'h0004
`define PCB_CFG_WMASK          16'h001E
`define PCB_CFG_FIXED          16'h0001
`define PCB_LOCK_WMASK         16'h00E0
`define PCB_FEATURE_FIXED      16'h0020
`define PCB_VOUT_FMT_WMASK     16'h0007
`define PCB_VOUT_FMT_FIXED     16'h0000
`define PCB_SETPOINT_WMASK     16'h0FFF
`define PCB_LOOP_WMASK         16'hFBFF
`define PCB_MON_WMASK          16'h3BFF
`define PCB_VIN_WMASK          16'h07FF
`define PCB_VIN_EXP_LSB        11
// Reset values (operating memory, before any restore)
`define PCB_TURN_ON_RESET      16'h0080
`define PCB_CFG_RESET          16'h001E
`define PCB_LOCK_RESET         16'h0000
`define PCB_VOUT_FMT_RESET     16'h0000
`define PCB_SETPOINT_RESET     16'h0000
`define PCB_LOOP_RESET         16'h0000
`define PCB_MON_RESET          16'h0000
`define PCB_VIN_RESET          16'h0000
// Software port map of the host controller
`define PCB_HREG_CMD           4'h0
`define PCB_HREG_DATA          4'h1
`define PCB_HREG_GO            4'h2
`define PCB_HREG_STATUS        4'h3
`define PCB_HREG_RDATA         4'h4
// Op codes written to the go register
`define PCB_OP_WRITE           2'h1
`define PCB_OP_READ            2'h2
`define PCB_OP_SEND            2'h3
`endif

// >>> pcb_pkg.sv
// Types shared by both ends of the power command bank
package pcb_pkg;
   typedef enum logic [1:0] {
      PCB_KIND_WRITE,
      PCB_KIND_READ,
      PCB_KIND_SEND
   } pcb_kind_type;
endpackage

// >>> pcb_link_if.sv
// Command link between the bank host and the bank device
`timescale 1ns/1ps
`default_nettype none
interface pcb_link_if;
   logic                  req;      // Request strobe, one cycle
   pcb_pkg::pcb_kind_type kind;     // Transaction kind
   logic [7:0]            code;     // Command code
   logic [15:0]           wdata;    // Write data
   logic                  ack;      // Answer strobe, one cycle
   logic [15:0]           rdata;    // Read answer
   logic                  blocked;  // Write refused by lock or unknown
   modport host (output req, kind, code, wdata, input ack, rdata, blocked);
   modport device (input req, kind, code, wdata, output ack, rdata, blocked);
endinterface
`default_nettype wire

// >>> pcb_pin_sync.sv
// Two-stage synchroniser for the supply switch pin
`timescale 1ns/1ps
`default_nettype none
module pcb_pin_sync (
   input  wire logic clock,    // System clock
   input  wire logic rst,      // Synchronous reset
   input  wire logic pin_in,   // Asynchronous pin
   output logic      pin_sync  // Synchronised level
);
   typedef struct packed {
      logic first;
      logic second;
   } pcb_sync_type;
   pcb_sync_type state_reg;
   pcb_sync_type state_next;

   // First stage feeds only the second
   always_comb begin
      state_next.first  = pin_in;
      state_next.second = state_reg.first;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign pin_sync = state_reg.second;
endmodule
`default_nettype wire

// >>> pcb_bank_device.sv
// Device end: standard power command register bank and turn-on logic
`timescale 1ns/1ps
`default_nettype none
`include "pcb_params.svh"

// Notes on behaviour
// - turn-on bit 7 off immediately, 1 on
// - bit 6 zero, margin field fixed 00
// - margin fault response reads fixed 01
// - config bit 4: pin and command gate start
// - config bit 3: command bit must be set
// - config bit 2: pin must be asserted
// - config bit 1: pin polarity, 1 high
// - config bit 0 always reads one
// - send 0x03 clears latched fault bits; same-cycle events stay set
// - three lock levels block other writes
// - send 0x12 loads factory defaults
// - send 0x15 stores operating memory to user
// - send 0x16 loads stored user settings
// - feature bit 7 zero, no error checking
// - feature bus speed field fixed 01
// - feature bit 4 zero, no alert pin
// - format field 7:5 fixed linear
// - format exponent 2:0 writable
// - setpoint 12-bit mantissa, top nibble zero
// - loop scaling exponent, bit 10 zero, mantissa
// - monitor scaling exponent, bits zero, mantissa
// - input threshold mantissa 10:0 writable
// - input threshold exponent from external field
module pcb_bank_device (
   input  wire logic       clock,            // System clock, 50 MHz
   input  wire logic       rst,              // Synchronous reset
   pcb_link_if.device      link,             // Command link from host
   input  wire logic       supply_switch_pin,// Asynchronous on/off pin
   input  wire logic [2:0] vin_exponent,     // Input voltage exponent field
   input  wire logic [7:0] fault_in,         // Fault events to latch
   output logic            output_enable,    // Converter enabled
   output logic [7:0]      fault_flags,      // Latched faults
   output logic [11:0]     vout_mantissa,    // Output target mantissa
   output logic [2:0]      vout_exponent,    // Output target exponent
   output logic [15:0]     loop_scale,       // Loop scaling word
   output logic [15:0]     monitor_scale,    // Monitor scaling word
   output logic [10:0]     input_start_threshold_mantissa   // Start threshold mantissa
);
   localparam int NREG = 8;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NREG-1:0][15:0] op;      // Operating memory
      logic [NREG-1:0][15:0] user;    // Stored user page
      logic [7:0]            faults;
      logic                  ack;
      logic                  blocked;
      logic [15:0]           rdata;
      logic                  enable;
   } pcb_dev_type;
   pcb_dev_type state_reg;
   pcb_dev_type state_next;
   logic        pin_sync;

   pcb_pin_sync u_pin_sync (
      .clock    (clock),
      .rst      (rst),
      .pin_in   (supply_switch_pin),
      .pin_sync (pin_sync)
   );

   // Map a command code to its slot; -1 when not a stored register
   function automatic int slot_of(input logic [7:0] c);
      case (c)
         `PCB_CMD_TURN_ON:       slot_of = 0;
         `PCB_CMD_ON_OFF_CFG:    slot_of = 1;
         `PCB_CMD_WRITE_LOCK:    slot_of = 2;
         `PCB_CMD_VOUT_FORMAT:   slot_of = 3;
         `PCB_CMD_VOUT_SETPOINT: slot_of = 4;
         `PCB_CMD_LOOP_SCALE:    slot_of = 5;
         `PCB_CMD_MON_SCALE:     slot_of = 6;
         `PCB_CMD_VIN_START:     slot_of = 7;
         default:                slot_of = -1;
      endcase
   endfunction

   // Writable bits per slot; everything else is fixed or reserved
   function automatic logic [15:0] wmask(input int s);
      case (s)
         0:       wmask = `PCB_TURN_ON_WMASK;
         1:       wmask = `PCB_CFG_WMASK;
         2:       wmask = `PCB_LOCK_WMASK;
         3:       wmask = `PCB_VOUT_FMT_WMASK;
         4:       wmask = `PCB_SETPOINT_WMASK;
         5:       wmask = `PCB_LOOP_WMASK;
         6:       wmask = `PCB_MON_WMASK;
         7:       wmask = `PCB_VIN_WMASK;
         default: wmask = 16'h0000;
      endcase
   endfunction

   function automatic logic [15:0] reset_of(input int s);
      case (s)
         0:       reset_of = `PCB_TURN_ON_RESET;
         1:       reset_of = `PCB_CFG_RESET;
         2:       reset_of = `PCB_LOCK_RESET;
         3:       reset_of = `PCB_VOUT_FMT_RESET;
         4:       reset_of = `PCB_SETPOINT_RESET;
         5:       reset_of = `PCB_LOOP_RESET;
         6:       reset_of = `PCB_MON_RESET;
         7:       reset_of = `PCB_VIN_RESET;
         default: reset_of = 16'h0000;
      endcase
   endfunction

   // Lock levels: lock register permits only listed commands
   function automatic logic write_allowed(input logic [7:0] c, input logic [15:0] lock);
      if (c == `PCB_CMD_WRITE_LOCK) begin
         write_allowed = 1'b1;
      end else if (lock[`PCB_LOCK_ALL_BIT]) begin
         write_allowed = 1'b0;
      end else if (lock[`PCB_LOCK_MOST_BIT]) begin
         write_allowed = (c == `PCB_CMD_TURN_ON);
      end else if (lock[`PCB_LOCK_SOME_BIT]) begin
         write_allowed = (c == `PCB_CMD_TURN_ON) || (c == `PCB_CMD_ON_OFF_CFG)
                      || (c == `PCB_CMD_VOUT_SETPOINT);
      end else begin
         write_allowed = 1'b1;
      end
   endfunction

   // ------------------------------------------------------------
   // Transaction handling and enable decision
   // ------------------------------------------------------------
   always_comb begin
      int          s;
      logic [15:0] cfg;
      logic        pin_on;
      logic        cmd_ok;
      logic        pin_ok;
      s              = slot_of(link.code);
      cfg    = state_reg.op[1];
      pin_on = cfg[`PCB_CFG_POLARITY_BIT] ? pin_sync : ~pin_sync;
      cmd_ok = ~cfg[`PCB_CFG_CMD_EN_BIT]
             | state_reg.op[0][`PCB_TURN_ON_ENABLE_BIT];
      pin_ok = ~cfg[`PCB_CFG_PIN_EN_BIT] | pin_on;
      state_next     = state_reg;
      state_next.ack = 1'b0;
      // Sticky faults; a new event beats a clear in the same cycle
      state_next.faults = state_reg.faults | fault_in;
      if (link.req) begin
         state_next.ack     = 1'b1;
         state_next.blocked = 1'b0;
         case (link.kind)
            pcb_pkg::PCB_KIND_WRITE: begin
               // Refused writes still ack, flagged, nothing stored
               if (s >= 0 && write_allowed(link.code, state_reg.op[2])) begin
                  state_next.op[s] = (state_reg.op[s] & ~wmask(s))
                                   | (link.wdata & wmask(s));
               end else begin
                  state_next.blocked = 1'b1;
               end
            end
            pcb_pkg::PCB_KIND_READ: begin
               case (link.code)
                  `PCB_CMD_TURN_ON:
                     state_next.rdata = (state_reg.op[0] & `PCB_TURN_ON_WMASK)
                                      | `PCB_TURN_ON_FIXED;
                  `PCB_CMD_ON_OFF_CFG:
                     state_next.rdata = (state_reg.op[1] & `PCB_CFG_WMASK)
                                      | `PCB_CFG_FIXED;
                  `PCB_CMD_BUS_FEATURE:
                     state_next.rdata = `PCB_FEATURE_FIXED;
                  `PCB_CMD_VOUT_FORMAT:
                     state_next.rdata = (state_reg.op[3] & `PCB_VOUT_FMT_WMASK)
                                      | `PCB_VOUT_FMT_FIXED;
                  `PCB_CMD_VIN_START:
                     state_next.rdata = (state_reg.op[7] & `PCB_VIN_WMASK)
                        | {{2{vin_exponent[2]}}, vin_exponent, 11'h000};
                  default:
                     state_next.rdata = (s >= 0) ? (state_reg.op[s] & wmask(s))
                                                 : 16'h0000;
               endcase
            end
            pcb_pkg::PCB_KIND_SEND: begin
               case (link.code)
                  `PCB_CMD_CLEAR_FAULTS: state_next.faults = fault_in;
                  `PCB_CMD_RESTORE_DEF: begin
                     for (int i = 0; i < NREG; i++) begin
                        state_next.op[i] = reset_of(i);
                     end
                  end
                  `PCB_CMD_STORE_USER:   state_next.user = state_reg.op;
                  `PCB_CMD_RESTORE_USER: state_next.op = state_reg.user;
                  default:               state_next.blocked = 1'b1;
               endcase
            end
            default: state_next.blocked = 1'b1;
         endcase
      end
      // Enable decision; PEC bytes never exist on this link
      // Immediate off: no sequencing delay when the enable drops
      state_next.enable = cfg[`PCB_CFG_POWERUP_BIT] ? (cmd_ok & pin_ok) : 1'b1;
   end

   // User page is a copy of defaults until first store
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= '0;
         for (int i = 0; i < NREG; i++) begin
            state_reg.op[i]   <= reset_of(i);
            state_reg.user[i] <= reset_of(i);
         end
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign link.ack        = state_reg.ack;
   assign link.rdata      = state_reg.rdata;
   assign link.blocked    = state_reg.blocked;
   assign output_enable   = state_reg.enable;
   assign fault_flags     = state_reg.faults;
   assign vout_mantissa   = state_reg.op[4][11:0];
   assign vout_exponent   = state_reg.op[3][2:0];
   assign loop_scale      = state_reg.op[5] & `PCB_LOOP_WMASK;
   assign monitor_scale   = state_reg.op[6] & `PCB_MON_WMASK;
   assign input_start_threshold_mantissa = state_reg.op[7][10:0];
endmodule
`default_nettype wire

// >>> pcb_bank_host.sv
// Host end: software port that issues commands to the bank device
`timescale 1ns/1ps
`default_nettype none
`include "pcb_params.svh"
module pcb_bank_host (
   input  wire logic        clock,  // System clock, 50 MHz
   input  wire logic        rst,    // Synchronous reset
   input  wire logic [3:0]  addr,   // Software register address
   input  wire logic [15:0] wdata,  // Software write data
   input  wire logic        wr,     // Write strobe
   input  wire logic        rd,     // Read strobe
   output logic [15:0]      rdata,  // Read data, cycle after rd
   pcb_link_if.host         link    // Command link to device
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]            code;
      logic [15:0]           data;
      logic                  busy;
      logic                  done;
      logic                  blocked;
      logic [15:0]           answer;
      logic                  req;
      pcb_pkg::pcb_kind_type kind;
      logic [15:0]           rdata;
   } pcb_host_type;
   pcb_host_type state_reg;
   pcb_host_type state_next;

   // Software writes, link answer capture, and read mux
   always_comb begin
      state_next     = state_reg;
      state_next.req = 1'b0;
      if (wr) begin
         case (addr)
            `PCB_HREG_CMD:  state_next.code = wdata[7:0];
            `PCB_HREG_DATA: state_next.data = wdata;
            `PCB_HREG_GO: begin
               // A new go while busy is dropped: one command in flight
               if (!state_reg.busy && wdata[1:0] != 2'h0) begin
                  state_next.req  = 1'b1;
                  state_next.busy = 1'b1;
                  state_next.done = 1'b0;
                  case (wdata[1:0])
                     `PCB_OP_WRITE: state_next.kind = pcb_pkg::PCB_KIND_WRITE;
                     `PCB_OP_READ:  state_next.kind = pcb_pkg::PCB_KIND_READ;
                     default:       state_next.kind = pcb_pkg::PCB_KIND_SEND;
                  endcase
               end
            end
            default: ;
         endcase
      end
      if (link.ack) begin
         state_next.busy    = 1'b0;
         state_next.done    = 1'b1;
         state_next.blocked = link.blocked;
         state_next.answer  = link.rdata;
      end
      state_next.rdata = 16'h0000;
      if (rd) begin
         case (addr)
            `PCB_HREG_CMD:    state_next.rdata = {8'h00, state_reg.code};
            `PCB_HREG_DATA:   state_next.rdata = state_reg.data;
            `PCB_HREG_STATUS: state_next.rdata = {13'h0000, state_reg.blocked,
                                                  state_reg.done, state_reg.busy};
            `PCB_HREG_RDATA:  state_next.rdata = state_reg.answer;
            default:          state_next.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata      = state_reg.rdata;
   assign link.req   = state_reg.req;
   assign link.kind  = state_reg.kind;
   assign link.code  = state_reg.code;
   assign link.wdata = state_reg.data;
endmodule
`default_nettype wire

// >>> pcb_link_properties.sv
// Checker for the command link between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module pcb_link_properties (
   input wire logic                  clock,   // System clock
   input wire logic                  rst,     // Synchronous reset
   input wire logic                  req,     // Request strobe
   input wire pcb_pkg::pcb_kind_type kind,    // Transaction kind
   input wire logic [7:0]            code,    // Command code
   input wire logic [15:0]           wdata,   // Write data
   input wire logic                  ack,     // Answer strobe
   input wire logic [15:0]           rdata,   // Read answer
   input wire logic                  blocked  // Refusal flag
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [2:0] lock_reg;       // Live lock level seen on the link
   logic [2:0] user_lock_reg;  // Lock level held in the user page
   // Follow restores too, or refusals after them look wrong
   always_ff @(posedge clock) begin
      if (rst) begin
         lock_reg <= 3'h0;
         user_lock_reg <= 3'h0;
      end else if (req && kind == pcb_pkg::PCB_KIND_WRITE && code == 8'h10) begin
         lock_reg <= wdata[7:5];
      end else if (req && kind == pcb_pkg::PCB_KIND_SEND) begin
         if (code == 8'h12) lock_reg <= 3'h0;
         if (code == 8'h15) user_lock_reg <= lock_reg;
         if (code == 8'h16) lock_reg <= user_lock_reg;
      end
   end
   // Highest lock bit wins; unknown codes are always refused
   function automatic logic refused(logic [7:0] c, logic [2:0] l);
      if (!(c inside {8'h01, 8'h02, 8'h10, 8'h20, 8'h21, 8'h29, 8'h2A, 8'h35})) return 1'b1;
      if (c == 8'h10) return 1'b0;
      if (l[2]) return 1'b1;
      if (l[1]) return c != 8'h01;
      if (l[0]) return !(c inside {8'h01, 8'h02, 8'h21});
      return 1'b0;
   endfunction
   function automatic logic fixed_ok(logic [7:0] c, logic [15:0] d);
      case (c)
         8'h01: return d[6:0] == 7'h04;
         8'h02: return d[7:5] == 3'h0 && d[0];
         8'h19: return d == 16'h0020;
         8'h20: return d[7:3] == 5'h00;
         8'h21: return d[15:12] == 4'h0;
         8'h29: return !d[10];
         8'h2A: return d[15:14] == 2'h0 && !d[10];
         default: return 1'b1;
      endcase
   endfunction
   // -----------------------------------------------------------
   // Link properties
   // -----------------------------------------------------------
   sequence s_write; req && kind == pcb_pkg::PCB_KIND_WRITE; endsequence
   sequence s_read; req && kind == pcb_pkg::PCB_KIND_READ; endsequence
   sequence s_send; req && kind == pcb_pkg::PCB_KIND_SEND && code inside {8'h03, 8'h12, 8'h15, 8'h16}; endsequence
   sequence s_answer; ack; endsequence
   property p_ack_next; req |=> s_answer; endproperty
   property p_ack_cause; ack |-> $past(req); endproperty
   property p_req_gap; req |=> !req; endproperty
   property p_lock_write; s_write |=> ack && blocked == refused($past(code), $past(lock_reg)); endproperty
   property p_read_open; s_read |=> s_answer ##0 !blocked; endproperty
   property p_fixed_bits; s_read |=> fixed_ok($past(code), rdata); endproperty
   property p_send_ok; s_send |=> ack && !blocked; endproperty
   property p_answer_hold; !ack |-> $stable(rdata) && $stable(blocked); endproperty
   a_ack_next: assert property (p_ack_next) else $error("no answer after request");
   a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
   a_req_gap: assert property (p_req_gap) else $error("requests back to back");
   a_lock_write: assert property (p_lock_write) else $error("lock refusal wrong");
   a_read_open: assert property (p_read_open) else $error("read refused");
   a_fixed_bits: assert property (p_fixed_bits) else $error("fixed field wrong");
   a_send_ok: assert property (p_send_ok) else $error("send refused");
   a_answer_hold: assert property (p_answer_hold) else $error("answer moved");
endmodule
`default_nettype wire

// >>> test_pmbus_standard_command_bank.sv
// Testbench: host and device ends on one link, against a register model
`timescale 1ns/1ps
`default_nettype none
`include "pcb_params.svh"
`define TB_CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
   $display("wrong value at %0t ns: got %h want %h", $time, got, exp); end end
module test_pmbus_standard_command_bank;
   // Bench nets
   logic        clock, rst, wr, rd, pin, output_enable;
   logic [2:0]  vin_exp, vout_exponent;
   logic [3:0]  addr;
   logic [7:0]  fault_in, fault_flags;
   logic [10:0] input_start_threshold_mantissa;
   logic [11:0] vout_mantissa;
   logic [15:0] wdata, rdata, loop_scale, monitor_scale;
   int          num_errors, n_compared, seed, flt;
   int          mem[256];
   int          usr[256];
   int          codes[9] = '{'h01, 'h02, 'h10, 'h19, 'h20, 'h21, 'h29, 'h2A, 'h35};
   int          locks[4] = '{'h80, 'h40, 'h20, 'h60};
   pcb_link_if link ();
   pcb_bank_host pcb_bank_host_i (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .link(link));
   pcb_bank_device pcb_bank_device_i (.clock(clock), .rst(rst), .link(link),
      .supply_switch_pin(pin), .vin_exponent(vin_exp), .fault_in(fault_in),
      .output_enable(output_enable), .fault_flags(fault_flags),
      .vout_mantissa(vout_mantissa), .vout_exponent(vout_exponent), .loop_scale(loop_scale),
      .monitor_scale(monitor_scale), .input_start_threshold_mantissa(input_start_threshold_mantissa));
   pcb_link_properties pcb_link_properties_i (.clock(clock), .rst(rst), .req(link.req),
      .kind(link.kind), .code(link.code), .wdata(link.wdata), .ack(link.ack),
      .rdata(link.rdata), .blocked(link.blocked));
   // Free-running 50 MHz clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // -----------------------------------------------------------
   // Register model
   // -----------------------------------------------------------
   function automatic void defaults();
      foreach (mem[i]) mem[i] = 0;
      mem[1] = 'h80;
      mem[2] = 'h1E;
   endfunction
   function automatic int wmask(int c);
      case (c)
         'h01: return 16'h0080;
         'h02: return 16'h001E;
         'h10: return 16'h00E0;
         'h20: return 16'h0007;
         'h21: return 16'h0FFF;
         'h29: return 16'hFBFF;
         'h2A: return 16'h3BFF;
         'h35: return 16'h07FF;
         default: return 0;
      endcase
   endfunction
   function automatic int exp_read(int c);
      int f;
      f = (c == 'h01) ? 4 : (c == 'h02) ? 1 : (c == 'h19) ? 'h20 : 0;
      if (c == 'h35) f = {vin_exp[2], vin_exp[2], vin_exp, 11'h000};
      return (mem[c] & wmask(c)) | f;
   endfunction
   // Unknown and read-only codes count as refused writes
   function automatic logic refused(int c);
      if (wmask(c) == 0) return 1'b1;
      if (c == 'h10) return 1'b0;
      if (mem[16][7]) return 1'b1;
      if (mem[16][6]) return c != 'h01;
      if (mem[16][5]) return !(c inside {'h01, 'h02, 'h21});
      return 1'b0;
   endfunction
   task automatic finish_test();
      if (num_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // One link command through the software port, polled with a bound
   task automatic run_op(input int c, input logic [15:0] d, input logic [1:0] o,
                         output logic [15:0] r, output logic b);
      logic [15:0] s;
      sw_write(`PCB_HREG_CMD, 16'(c));
      sw_write(`PCB_HREG_DATA, d);
      sw_write(`PCB_HREG_GO, {14'h0000, o});
      for (int i = 0; i < 20 && s[1:0] !== 2'b10; i++) sw_read(`PCB_HREG_STATUS, s);
      if (s[1:0] !== 2'b10) begin
         num_errors++;
         $display("wrong value at %0t ns: command never completed", $time);
         finish_test();
      end
      sw_read(`PCB_HREG_RDATA, r);
      b = s[2];
   endtask
   task automatic chk_out();
      logic en;
      repeat (4) @(posedge clock);
      en = !mem[2][4] || ((!mem[2][3] || mem[1][7]) && (!mem[2][2] || pin == mem[2][1]));
      `TB_CHECK(output_enable, en)
      `TB_CHECK(vout_exponent, 3'(mem[32]))
      `TB_CHECK(vout_mantissa, 12'(mem[33]))
      `TB_CHECK(loop_scale, 16'(mem[41] & 16'hFBFF))
      `TB_CHECK(monitor_scale, 16'(mem[42] & 16'h3BFF))
      `TB_CHECK(input_start_threshold_mantissa, 11'(mem[53]))
      `TB_CHECK(fault_flags, 8'(flt))
   endtask
   task automatic do_read(input int c);
      logic [15:0] r;
      logic        b;
      run_op(c, 16'h0000, `PCB_OP_READ, r, b);
      `TB_CHECK(r, 16'(exp_read(c)))
      `TB_CHECK(b, 1'b0)
   endtask
   task automatic do_write(input int c, input logic [15:0] d);
      logic [15:0] r;
      logic        b;
      logic        want;
      want = refused(c);
      run_op(c, d, `PCB_OP_WRITE, r, b);
      `TB_CHECK(b, want)
      if (!want) mem[c] = d;
      do_read(c);
      chk_out();
   endtask
   task automatic do_send(input int c);
      logic [15:0] r;
      logic        b;
      run_op(c, 16'h0000, `PCB_OP_SEND, r, b);
      `TB_CHECK(b, 1'b0)
      if (c == 'h03) flt = 0;
      if (c == 'h12) defaults();
      if (c == 'h15) usr = mem;
      if (c == 'h16) mem = usr;
   endtask
   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial begin
      seed = 32'h3B26196D;
      {num_errors, n_compared, flt} = '0;
      {rst, addr, wdata, wr, rd, pin, vin_exp, fault_in} = {1'b1, 23'h0, 3'h5, 8'h00};
      defaults();
      usr = mem;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      // Reset values and an unmapped code
      foreach (codes[i]) do_read(codes[i]);
      do_read('h7F);
      // Random data into every writable place except the lock register, then a refused unknown code
      repeat (4) begin
         @(posedge clock);
         vin_exp <= 3'($random(seed));
         foreach (codes[i]) if (codes[i] != 'h10) do_write(codes[i], 16'($random(seed)));
      end
      do_write('h7E, 16'hFFFF);
      // Each lock level against every register but the lock register; refused writes must leave stored values intact
      foreach (locks[j]) begin
         do_write('h10, 16'(locks[j]));
         foreach (codes[i]) if (codes[i] != 'h10) do_write(codes[i], 16'($random(seed)));
      end
      do_write('h10, 16'h0000);
      // Turn-on decision over config bits, command bit and pin level
      for (int i = 0; i < 64; i++) begin
         @(posedge clock);
         pin <= i[5];
         do_write('h01, {8'h00, i[4], 7'h00});
         do_write('h02, {11'h000, i[3:0], 1'b0});
      end
      // Faults latch until the clear command
      repeat (3) begin
         @(posedge clock);
         fault_in <= 8'($random(seed));
         @(posedge clock);
         flt = flt | fault_in;
         fault_in <= 8'h00;
      end
      chk_out();
      do_send('h03);
      chk_out();
      // Store, overwrite, restore user page, then factory defaults
      do_write('h21, 16'h0ABC);
      do_send('h15);
      do_write('h21, 16'h0123);
      do_write('h20, 16'h0005);
      do_send('h16);
      foreach (codes[i]) do_read(codes[i]);
      do_send('h12);
      foreach (codes[i]) do_read(codes[i]);
      chk_out();
      finish_test();
   end
endmodule
`default_nettype wire
